// ===== hdl/flash_id_cmd.sv
// Serial command interpreter for ID reads, parameter-table reads and security-register erase.
// Assumes chip select, serial clock and data lines are synchronous to mclk and that the
// serial clock runs at most at a quarter of mclk.
//
// Contract
// - Opcode 90h, zero 24-bit address, then manufacturer and device bytes, single lane.
// - Opcode 92h takes address two bits per clock and returns IDs two bits per clock.
// - Opcode 94h has four dummy clocks, address four bits per clock, quad output.
// - Dual and quad ID reads alternate manufacturer and device bytes while clocked.
// - Raising chip select ends every read and stops output drive.
// - Opcode 4Bh, 32 dummy clocks, then the fixed 64-bit unique number.
// - Opcode 9Fh returns manufacturer, memory type and capacity bytes, MSB first.
// - The 9Fh read works in serial mode and in four-lane command mode.
// - Dual, quad, unique ID and erase work only in serial mode.
// - Opcode 5Ah address low byte selects the start byte in the 256-byte table.
// - Parameter table data starts on the falling edge of clock forty.
// - Erase 44h runs only when the write latch flag is set.
// - Erase address picks register one to three through bits 15 to 12.
// - Chip select must rise right after the last address byte, else discard.
// - Erase is self-timed with busy high throughout; status stays readable.
// - Erase completion clears the write latch flag.
// - A set lock bit makes erases of that register ignored.
// - ID reads issued while busy are ignored and leave the cycle running.
`default_nettype none

// Byte FIFO between the read-byte fetcher and the output shifter.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("byte_fifo depth must be a power of two of at least two");
  end

  // Flags follow the occupancy count, so full and empty are exact.
  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // Storage has no reset; only pointers and count need a defined value.
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  // Pointers and count; flush empties the queue at frame end.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : byte_fifo

module flash_id_cmd #(
  parameter logic [7:0]  MFR_ID       = 8'h5a, // Arbitrary value.
  parameter logic [7:0]  DEV_ID       = 8'h16, // Arbitrary value.
  parameter logic [7:0]  MEM_TYPE_ID  = 8'h40, // Arbitrary value.
  parameter logic [7:0]  CAPACITY_ID  = 8'h17, // Arbitrary value.
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89ab_cdef, // Arbitrary value.
  parameter int          ERASE_CYCLES = flash_id_pkg::ERASE_CYCLES_DFLT,
  parameter int          FIFO_DEPTH   = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  input  wire logic [3:0]            io_in,
  output flash_id_pkg::io_drive_t    io_drv,
  input  wire logic                  qpi_mode,
  input  wire logic                  other_busy,
  input  wire logic                  wel_set,
  input  wire logic [2:0]            otp_lock_bits,
  input  wire logic                  sfdp_wr_en,
  input  wire logic [7:0]            sfdp_wr_addr,
  input  wire logic [7:0]            sfdp_wr_data,
  output logic                       write_latch_flag,
  output logic                       busy_flag,
  output logic [1:0]                 erase_sel,
  output logic                       erase_done
);
  import flash_id_pkg::*;

  logic [7:0]  sfdp_mem [256];
  phase_t      phase_r;
  lane_t       lanes_r;
  logic [4:0]  cnt_r;
  logic [7:0]  op_sh_r;
  logic [7:0]  cmd_r;
  logic [23:0] addr_r;
  logic        sclk_q;
  logic        cs_q;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  logic [7:0]  op_nxt;
  logic [7:0]  out_sh_r;
  logic [3:0]  bits_left_r;
  logic [7:0]  fetch_idx_r;
  logic        fetch_ready;
  logic        q_valid;
  logic        q_pop;
  logic [7:0]  q_data;
  logic [7:0]  fetch_byte;
  logic [5:0]  clk_total_r;
  logic        busy_r;
  logic [31:0] erase_cnt_r;
  logic        wel_r;
  logic        erase_ok;
  io_drive_t   drv_r;

  if (ERASE_CYCLES < 8) begin : g_erase_chk
    $error("ERASE_CYCLES must be at least 8");
  end

  // Shift helper: appends the lanes that carry data in the current width.
  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] io, input lane_t w);
    case (w)
      LANE_X1: shift_in = {v[22:0], io[0]};
      LANE_X2: shift_in = {v[21:0], io[1:0]};
      LANE_X4: shift_in = {v[19:0], io[3:0]};
      default: shift_in = v;
    endcase
  endfunction : shift_in

  // Bits moved per clock for a width.
  function automatic logic [3:0] lane_bits(input lane_t w);
    case (w)
      LANE_X2: lane_bits = 4'h2;
      LANE_X4: lane_bits = 4'h4;
      default: lane_bits = 4'h1;
    endcase
  endfunction : lane_bits

  // Edge detection on the already synchronous serial clock and chip select.
  assign rise    = sclk && !sclk_q && !cs_n;
  assign fall    = !sclk && sclk_q && !cs_n;
  assign cs_rise = cs_n && !cs_q;
  assign op_nxt  = qpi_mode ? {op_sh_r[3:0], io_in} : {op_sh_r[6:0], io_in[0]};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
    end
  end

  // Parameter table is loaded by the surrounding system, never by the serial host.
  always_ff @(posedge mclk)
  begin
    if (sfdp_wr_en)
      sfdp_mem[sfdp_wr_addr] <= sfdp_wr_data;
  end

  // Command sequencer: phases advance on rising serial edges; data and ignore phases hold until deselect.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      phase_r <= ST_OPC;
      lanes_r <= LANE_X1;
      cnt_r   <= OPC_LAST_X1;
      op_sh_r <= 8'h00;
      cmd_r   <= 8'h00;
      addr_r  <= 24'h000000;
    end else if (cs_n) begin
      phase_r <= ST_OPC;
      lanes_r <= LANE_X1;
      cnt_r   <= qpi_mode ? OPC_LAST_X4 : OPC_LAST_X1;
    end else if (rise) begin
      cnt_r <= cnt_r - 5'h01;
      case (phase_r)
        ST_OPC:
        begin
          op_sh_r <= op_nxt;
          if (cnt_r == 5'h00) begin
            cmd_r  <= op_nxt;
            addr_r <= 24'h000000;
            if (qpi_mode && op_nxt != OP_JEDEC)
              phase_r <= ST_IGNORE;
            else if (busy_r || other_busy)
              phase_r <= ST_IGNORE;
            else begin
              case (op_nxt)
                OP_ID_SINGLE, OP_SFDP, OP_SEC_ERASE:
                begin
                  phase_r <= ST_ADDR;
                  cnt_r   <= ADDR_LAST_X1;
                end
                OP_ID_DUAL:
                begin
                  phase_r <= ST_ADDR;
                  lanes_r <= LANE_X2;
                  cnt_r   <= ADDR_LAST_X2;
                end
                OP_ID_QUAD:
                begin
                  phase_r <= ST_DUMMY;
                  lanes_r <= LANE_X4;
                  cnt_r   <= QUAD_PRE_LAST;
                end
                OP_UNIQUE:
                begin
                  phase_r <= ST_DUMMY;
                  cnt_r   <= UID_DUMMY_LAST;
                end
                OP_JEDEC:
                begin
                  phase_r <= ST_DATA;
                  lanes_r <= qpi_mode ? LANE_X4 : LANE_X1;
                end
                default: phase_r <= ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR:
        begin
          addr_r <= shift_in(addr_r, io_in, lanes_r);
          if (cnt_r == 5'h00) begin
            case (cmd_r)
              OP_ID_DUAL:
              begin
                phase_r <= ST_MODE;
                cnt_r   <= MODE_LAST_X2;
              end
              OP_ID_QUAD:
              begin
                phase_r <= ST_MODE;
                cnt_r   <= MODE_LAST_X4;
              end
              OP_SFDP:
              begin
                phase_r <= ST_DUMMY;
                cnt_r   <= SFDP_DUMMY_LAST;
              end
              OP_SEC_ERASE: phase_r <= ST_ERASE_WAIT;
              default:      phase_r <= ST_DATA;
            endcase
          end
        end
        // Mode bits are the host's business and are not inspected.
        ST_MODE:
        begin
          if (cnt_r == 5'h00)
            phase_r <= ST_DATA;
        end
        ST_DUMMY:
        begin
          if (cnt_r == 5'h00) begin
            if (cmd_r == OP_ID_QUAD) begin
              phase_r <= ST_ADDR;
              cnt_r   <= ADDR_LAST_X4;
            end else
              phase_r <= ST_DATA;
          end
        end
        ST_ERASE_WAIT: phase_r <= ST_IGNORE;
        default:       phase_r <= phase_r;
      endcase
    end
  end

  // Frame clock count; only used to check data start timing.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      clk_total_r <= 6'h00;
    else if (cs_n)
      clk_total_r <= 6'h00;
    else if (rise && clk_total_r != 6'h3f)
      clk_total_r <= clk_total_r + 6'h01;
  end

  // Byte source for the current read; the byte index walks the answer.
  always_comb
  begin
    case (cmd_r)
      OP_ID_SINGLE, OP_ID_DUAL, OP_ID_QUAD:
        fetch_byte = fetch_idx_r[0] ? DEV_ID : MFR_ID;
      OP_JEDEC:
        case (fetch_idx_r)
          8'h00:   fetch_byte = MFR_ID;
          8'h01:   fetch_byte = MEM_TYPE_ID;
          8'h02:   fetch_byte = CAPACITY_ID;
          default: fetch_byte = 8'h00;
        endcase
      OP_UNIQUE:
        fetch_byte = (fetch_idx_r < 8'h08) ? UNIQUE_ID[8'd63 - {fetch_idx_r[4:0], 3'b000} -: 8] : 8'h00;
      OP_SFDP:
        fetch_byte = sfdp_mem[addr_r[7:0] + fetch_idx_r];
      default:
        fetch_byte = 8'h00;
    endcase
  end

  // Fetch index advances when the queue takes a byte; it stalls while the queue is full.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fetch_idx_r <= 8'h00;
    else if (cs_n)
      fetch_idx_r <= 8'h00;
    else if (phase_r == ST_DATA && fetch_ready)
      fetch_idx_r <= fetch_idx_r + 8'h01;
  end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_out_q (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .flush     (cs_n),
    .in_valid  (phase_r == ST_DATA),
    .in_ready  (fetch_ready),
    .in_data   (fetch_byte),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  assign q_pop = fall && phase_r == ST_DATA && bits_left_r == 4'h0;

  // Output shifter: data changes on falling serial edges, MSB first.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      drv_r       <= '{oe: OE_IDLE, dat: 4'h0};
      out_sh_r    <= 8'h00;
      bits_left_r <= 4'h0;
    end else if (cs_n) begin
      drv_r       <= '{oe: OE_IDLE, dat: 4'h0};
      bits_left_r <= 4'h0;
    end else if (fall && phase_r == ST_DATA) begin
      // An underrun shifts out zeros rather than stale bits.
      logic [7:0] b;
      b = (bits_left_r == 4'h0) ? (q_valid ? q_data : 8'h00) : out_sh_r;
      case (lanes_r)
        LANE_X2:
        begin
          drv_r <= '{oe: OE_X2, dat: {2'b00, b[7:6]}};
          out_sh_r <= {b[5:0], 2'b00};
        end
        LANE_X4:
        begin
          drv_r <= '{oe: OE_X4, dat: b[7:4]};
          out_sh_r <= {b[3:0], 4'h0};
        end
        default:
        begin
          drv_r <= '{oe: OE_X1, dat: {2'b00, b[7], 1'b0}};
          out_sh_r <= {b[6:0], 1'b0};
        end
      endcase
      bits_left_r <= ((bits_left_r == 4'h0) ? 4'h8 : bits_left_r) - lane_bits(lanes_r);
    end
  end

  // Erase acceptance is decided at chip select rise on an exact byte boundary.
  assign erase_ok = phase_r == ST_ERASE_WAIT && wel_r
                    && addr_r[23:16] == SECREG_HI_BYTE && addr_r[11:8] == SECREG_MID_NIB
                    && addr_r[15:12] >= SECREG_SEL_MIN && addr_r[15:12] <= SECREG_SEL_MAX
                    && !otp_lock_bits[addr_r[13:12] - 2'd1];

  // Self-timed erase engine; the busy flag is a plain output so status stays visible.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      busy_r      <= 1'b0;
      erase_cnt_r <= '0;
      erase_sel   <= 2'd0;
      erase_done  <= 1'b0;
    end else begin
      erase_done <= 1'b0;
      if (cs_rise && erase_ok) begin
        busy_r      <= 1'b1;
        erase_cnt_r <= 32'(ERASE_CYCLES - 1);
        erase_sel   <= addr_r[13:12];
      end else if (busy_r) begin
        if (erase_cnt_r == '0) begin
          busy_r     <= 1'b0;
          erase_done <= 1'b1;
        end else
          erase_cnt_r <= erase_cnt_r - 32'd1;
      end
    end
  end

  // Write latch: a set request in the completion cycle wins over the clear.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wel_r <= 1'b0;
    else if (wel_set)
      wel_r <= 1'b1;
    else if (busy_r && erase_cnt_r == '0)
      wel_r <= 1'b0;
  end

  assign io_drv           = drv_r;
  assign write_latch_flag = wel_r;
  assign busy_flag        = busy_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_cs_stops_drive:   assert property (cs_n |=> io_drv.oe == OE_IDLE) else $error("drive after cs high");
  a_busy_ignores_id:  assert property (rise && phase_r == ST_OPC && cnt_r == 5'h00 && (busy_r || other_busy) && !cs_n
                        |=> phase_r == ST_IGNORE) else $error("command taken while busy");
  a_qpi_only_jedec:   assert property (rise && phase_r == ST_OPC && cnt_r == 5'h00 && qpi_mode && !cs_n
                        && op_nxt != OP_JEDEC |=> phase_r == ST_IGNORE) else $error("qpi accepted");
  a_erase_needs_wel:  assert property ($rose(busy_r) |-> $past(wel_r)) else $error("erase without latch");
  a_erase_lock_gate:  assert property ($rose(busy_r) |-> !otp_lock_bits[erase_sel - 2'd1]) else $error("locked erase");
  a_busy_holds:       assert property ($rose(busy_r) |-> busy_r [*8]) else $error("busy dropped early");
  a_done_clears_wel:  assert property ($fell(busy_r) && !$past(wel_set) |-> !wel_r) else $error("latch kept");
  a_erase_discard:    assert property ($rose(busy_r) |-> $past(phase_r) == ST_ERASE_WAIT)
                        else $error("erase started off a byte boundary");
  a_sfdp_start_clk:   assert property (phase_r == ST_DATA && $past(phase_r) != ST_DATA && cmd_r == OP_SFDP && !cs_n
                        |-> clk_total_r == SFDP_FIRST_OUT_CLK) else $error("sfdp start wrong");
  a_dual_lanes:       assert property (cmd_r == OP_ID_DUAL && io_drv.oe != OE_IDLE |-> io_drv.oe == OE_X2)
                        else $error("dual lanes wrong");

  c_erase_run:  cover property ($fell(busy_r));
  c_dual_read:  cover property (cmd_r == OP_ID_DUAL && io_drv.oe == OE_X2);
  c_sfdp_read:  cover property (cmd_r == OP_SFDP && q_pop);
  c_qpi_jedec:  cover property (cmd_r == OP_JEDEC && io_drv.oe == OE_X4);
endmodule : flash_id_cmd
`default_nettype wire

// ===== hdl/flash_id_pkg.sv
// Constants and types for the identification and security-register command block.
// Assumes a single 250 MHz clock and pins that are already synchronous to it.
`default_nettype none
package flash_id_pkg;
  // Opcodes handled by the block.
  localparam logic [7:0] OP_ID_SINGLE = 8'h90;
  localparam logic [7:0] OP_ID_DUAL   = 8'h92;
  localparam logic [7:0] OP_ID_QUAD   = 8'h94;
  localparam logic [7:0] OP_UNIQUE    = 8'h4b;
  localparam logic [7:0] OP_JEDEC     = 8'h9f;
  localparam logic [7:0] OP_SFDP      = 8'h5a;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  // Phase lengths as the last index of a down counter, in serial clocks, and the frame clock count at SFDP data start.
  localparam logic [4:0] OPC_LAST_X1  = 5'h07;
  localparam logic [4:0] OPC_LAST_X4  = 5'h01;
  localparam logic [4:0] ADDR_LAST_X1 = 5'h17;
  localparam logic [4:0] ADDR_LAST_X2 = 5'h0b;
  localparam logic [4:0] ADDR_LAST_X4 = 5'h05;
  localparam logic [4:0] MODE_LAST_X2 = 5'h03;
  localparam logic [4:0] MODE_LAST_X4 = 5'h01;
  localparam logic [4:0] QUAD_PRE_LAST = 5'h03;
  localparam logic [4:0] UID_DUMMY_LAST = 5'h1f;
  localparam logic [4:0] SFDP_DUMMY_LAST = 5'h07;
  localparam logic [5:0] SFDP_FIRST_OUT_CLK = 6'h28;
  // Security register address fields.
  localparam logic [7:0] SECREG_HI_BYTE = 8'h00;
  localparam logic [3:0] SECREG_MID_NIB = 4'h0;
  localparam logic [3:0] SECREG_SEL_MIN = 4'h1;
  localparam logic [3:0] SECREG_SEL_MAX = 4'h3;
  // Self-timed erase length.
  localparam int T_SE_NS  = 1000;
  localparam int MCLK_MHZ = 250;
  localparam int ERASE_CYCLES_DFLT = (T_SE_NS * MCLK_MHZ) / 1000;
  // Output lane enables per transfer width.
  localparam logic [3:0] OE_IDLE = 4'h0;
  localparam logic [3:0] OE_X1   = 4'h2;
  localparam logic [3:0] OE_X2   = 4'h3;
  localparam logic [3:0] OE_X4   = 4'hf;

  typedef enum {ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_ERASE_WAIT, ST_IGNORE} phase_t;
  typedef enum {LANE_X1, LANE_X2, LANE_X4} lane_t;

  // Pin drive bundle: enables and levels for the four data lines.
  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] dat;
  } io_drive_t;
endpackage : flash_id_pkg
`default_nettype wire

// ===== bench/spi_host_model.sv
// Host side serial controller model: frames commands and samples the device lanes.
// Assumes a device that registers its lanes on mclk and needs two mclk per sclk level.
`default_nettype none
module spi_host_model (
  input  wire logic                   mclk,
  output logic                        cs_n,
  output logic                        sclk,
  output logic [3:0]                  io_in,
  input  wire flash_id_pkg::io_drive_t io_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_id_pkg::*;
  logic [3:0] seen_oe;
  int         half;

  // Idle: deselected, clock parked low, so no edge is seen outside a frame.
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'h0;
    seen_oe = 4'h0;
    half = 3;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n

  task automatic open_frame();
    cs_n = 1'b0;
    wait_n(half);
  endtask : open_frame

  // One sclk per unit; lanes are sampled just before the rise, when the last fall has settled.
  task automatic shift(input int w, input int n, input logic [63:0] v, output logic [63:0] r);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    r = '0;
    for (int i = 0; i < n; i++)
    begin
      io_in = 4'(v >> ((n - 1 - i) * w)) & m;
      wait_n(half);
      seen_oe = io_drv.oe;
      r = (r << w) | 64'(w == 1 ? {3'h0, io_drv.dat[1]} : io_drv.dat & m);
      sclk = 1'b1;
      wait_n(half);
      sclk = 1'b0;
    end
  endtask : shift

  // Select rises on a unit boundary with the clock low; released lines show the inverse level.
  task automatic close_frame();
    wait_n(half);
    cs_n = 1'b1;
    io_in = ~io_in;
  endtask : close_frame
endmodule : spi_host_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the command block, driven through the host model.
// Assumes the design package, the design and the host model are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_id_pkg::*;
  localparam logic [7:0]  MFR = 8'ha3; // Arbitrary value.
  localparam logic [7:0]  DEV = 8'h3c; // Arbitrary value.
  localparam logic [7:0]  MT  = 8'h61; // Arbitrary value.
  localparam logic [7:0]  CAP = 8'h2e; // Arbitrary value.
  localparam logic [63:0] UID = 64'hf1e2_d3c4_b5a6_9788; // Arbitrary value.
  localparam int          EC  = 12;
  logic        mclk = 1'b0;
  logic        rst_n, cs_n, sclk, qpi_mode, other_busy, wel_set, sfdp_wr_en;
  logic [3:0]  io_in;
  io_drive_t   io_drv;
  logic [2:0]  otp_lock_bits;
  logic [7:0]  sfdp_wr_addr, sfdp_wr_data, st;
  logic        write_latch_flag, busy_flag, erase_done, wel_m;
  logic [1:0]  erase_sel;
  logic [7:0]  tbl [256];
  logic [63:0] r;
  int          failures = 0;
  int          total_checks = 0;

  flash_id_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE_ID(MT), .CAPACITY_ID(CAP), .UNIQUE_ID(UID),
    .ERASE_CYCLES(EC), .FIFO_DEPTH(4)) flash_id_cmd_i (.mclk, .rst_n, .cs_n, .sclk, .io_in, .io_drv,
    .qpi_mode, .other_busy, .wel_set, .otp_lock_bits, .sfdp_wr_en, .sfdp_wr_addr, .sfdp_wr_data,
    .write_latch_flag, .busy_flag, .erase_sel, .erase_done);
  spi_host_model spi_host_model_i (.mclk, .cs_n, .sclk, .io_in, .io_drv);

  // 250 MHz clock.
  always #2 mclk = ~mclk;

  task automatic stop_test();
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic neg(input int n);
    repeat (n) @(negedge mclk);
  endtask : neg

  task automatic send(input int w, input int n, input logic [63:0] v);
    spi_host_model_i.shift(w, n, v, r);
  endtask : send

  // Opcode takes two clocks on four lanes in command mode, else eight on one.
  task automatic cmd(input logic [7:0] op);
    spi_host_model_i.open_frame();
    send(qpi_mode ? 4 : 1, qpi_mode ? 2 : 8, 64'(op));
  endtask : cmd

  // Read data, close the frame, then see the lanes released.
  task automatic rd(input int w, input int n, input logic [63:0] exp, input logic [3:0] eoe);
    spi_host_model_i.shift(w, n, '1, r);
    if (eoe != OE_IDLE)
      check(r, exp);
    check(64'(spi_host_model_i.seen_oe), 64'(eoe));
    spi_host_model_i.close_frame();
    neg(3);
    check(64'(io_drv.oe), 64'h0);
  endtask : rd

  // One erase attempt; ok says whether it must run.
  task automatic erase(input logic we, input logic [23:0] a, input logic extra, input logic ok);
    int n;
    if (we)
    begin
      wel_set = 1'b1;
      wel_m = 1'b1;
      neg(1);
      wel_set = 1'b0;
    end
    check(64'(write_latch_flag), 64'(wel_m));
    cmd(OP_SEC_ERASE);
    send(qpi_mode ? 4 : 1, qpi_mode ? 6 : 24, 64'(a));
    if (extra)
      send(1, 1, 64'h0);
    spi_host_model_i.close_frame();
    neg(2);
    check(64'(busy_flag), 64'(ok));
    n = 0;
    while (busy_flag === 1'b1 && n < 1000)
    begin
      n++;
      neg(1);
    end
    if (ok)
    begin
      // Busy stands ERASE_CYCLES clocks; the first of them passes before the count starts.
      check(64'(n), 64'(EC - 1));
      check(64'({erase_done, erase_sel}), 64'({1'b1, a[13:12]}));
      check(64'(write_latch_flag), 64'h0);
      wel_m = 1'b0;
    end
    neg(4);
  endtask : erase

  // Hang guard, well beyond the few tens of microseconds the sequence needs.
  initial
  begin
    #200000;
    failures++;
    stop_test();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'hf4aa));
    {rst_n, qpi_mode, other_busy, wel_set, sfdp_wr_en, wel_m} = 6'h0;
    {otp_lock_bits, sfdp_wr_addr, sfdp_wr_data} = 19'h0;
    neg(12);
    check(64'({io_drv, write_latch_flag, busy_flag, erase_done}), 64'h0);
    rst_n = 1'b1;
    neg(2);
    for (int i = 0; i < 256; i++)
    begin
      tbl[i] = 8'($urandom);
      {sfdp_wr_en, sfdp_wr_addr, sfdp_wr_data} = {1'b1, 8'(i), tbl[i]};
      neg(1);
    end
    sfdp_wr_en = 1'b0;
    cmd(OP_ID_SINGLE);
    send(1, 24, 64'h0);
    rd(1, 32, 64'({MFR, DEV, MFR, DEV}), OE_X1);
    cmd(OP_ID_DUAL);
    send(2, 12, 64'h0);
    send(2, 4, 64'({4'hf, 4'($urandom)}));
    rd(2, 16, 64'({MFR, DEV, MFR, DEV}), OE_X2);
    cmd(OP_ID_QUAD);
    send(4, 4, 64'h0);
    send(4, 6, 64'h0);
    send(4, 2, 64'({4'hf, 4'($urandom)}));
    rd(4, 16, {MFR, DEV, MFR, DEV, MFR, DEV, MFR, DEV}, OE_X4);
    spi_host_model_i.half = 5;
    cmd(OP_UNIQUE);
    send(1, 32, 64'h0);
    rd(1, 64, UID, OE_X1);
    spi_host_model_i.half = 3;
    cmd(OP_JEDEC);
    rd(1, 32, 64'({MFR, MT, CAP, 8'h00}), OE_X1);
    // The opcode length is taken while deselected, so the mode must settle before the frame opens.
    qpi_mode = 1'b1;
    neg(1);
    cmd(OP_JEDEC);
    rd(4, 8, 64'({MFR, MT, CAP, 8'h00}), OE_X4);
    cmd(OP_ID_QUAD);
    send(4, 12, 64'h0);
    rd(4, 8, 64'h0, OE_IDLE);
    qpi_mode = 1'b0;
    other_busy = 1'b1;
    neg(1);
    cmd(OP_ID_SINGLE);
    send(1, 24, 64'h0);
    rd(1, 16, 64'h0, OE_IDLE);
    other_busy = 1'b0;
    // Table reads from the byte below the top one, across the wrap, then from a random byte.
    for (int k = 0; k < 2; k++)
    begin
      st = (k == 0) ? 8'hfe : 8'($urandom);
      cmd(OP_SFDP);
      send(1, 24, 64'({16'h0, st}));
      send(1, 8, 64'h0);
      rd(1, 32, 64'({tbl[st], tbl[8'(st + 1)], tbl[8'(st + 2)], tbl[8'(st + 3)]}), OE_X1);
    end
    // Each register erased, then every reason to refuse except busy.
    for (int s = 1; s <= 3; s++)
      erase(1'b1, {8'h00, 4'(s), 4'h0, 8'($urandom)}, 1'b0, 1'b1);
    erase(1'b0, 24'h001000, 1'b0, 1'b0);
    erase(1'b1, 24'h004000, 1'b0, 1'b0);
    erase(1'b1, 24'h011000, 1'b0, 1'b0);
    erase(1'b1, 24'h002100, 1'b0, 1'b0);
    erase(1'b1, 24'h001000, 1'b1, 1'b0);
    otp_lock_bits = 3'h2;
    erase(1'b1, 24'h0020ff, 1'b0, 1'b0);
    erase(1'b1, 24'h003000, 1'b0, 1'b1);
    qpi_mode = 1'b1;
    neg(1);
    erase(1'b1, 24'h001000, 1'b0, 1'b0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
